// *** include/ckg_pkg.sv ***
package ckg_pkg;

   // Register offsets
   localparam logic [7:0] REG_DRIVE_A = 8'h0c;
   localparam logic [7:0] REG_DRIVE_B = 8'h0d;
   localparam logic [7:0] REG_IDENT = 8'h0e;

   // Values after reset and write masks
   localparam logic [7:0] DRIVE_A_RST = 8'hb4;
   localparam logic [7:0] DRIVE_B_RST = 8'ha0;
   localparam logic [7:0] DRIVE_A_WMASK = 8'hfd;
   localparam logic [7:0] DRIVE_B_WMASK = 8'he1;
   localparam logic [1:0] SEL_EXT_RST = 2'h3;
   localparam logic [2:0] IDENT_RSVD = 3'h5;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Field positions
   localparam int USB_LSB = 5;
   localparam int PERIPH0_LSB = 2;
   localparam int FREE_LSB = 5;
   localparam int SEL_BIT1_POS = 0;
   localparam int WIRELESS_POS = 0;
   localparam int IDENT_LSB = 0;

   // Drive codes: 000 strongest, 111 weakest
   localparam logic [2:0] CODE_STRONG = 3'h0;
   localparam logic [2:0] CODE_NORMAL = 3'h5;
   localparam logic [2:0] CODE_WIRELESS = 3'h7;

   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int PU_LATENCY_NS = 1800000;
   localparam int DIFF_DRIVE_NS = 300000;
   localparam int PU_LATENCY_CYC = PU_LATENCY_NS / CLK_PERIOD_NS;
   localparam int DIFF_DRIVE_CYC = DIFF_DRIVE_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_PWRGD = 3'b000,
      ST_RUN = 3'b001,
      ST_DRAIN = 3'b010,
      ST_OFF = 3'b011,
      ST_WAKE = 3'b100
   } ckg_state_t;

   typedef struct packed {
      logic [2:0] usb;
      logic [2:0] periph0;
      logic [2:0] free_periph;
      logic [2:0] selectable;
   } ckg_drive_t;

   typedef struct packed {
      logic true_ph;
      logic comp_ph;
   } ckg_diff_t;

endpackage

// *** hw/ckg_clk_gate.sv ***
`timescale 1ns/1ps
module ckg_clk_gate (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Control
   input wire logic tick_in,
   input wire logic stop_in,
   input wire logic rest_in,
   // Gated clock
   output logic true_out,
   output logic comp_out,
   output logic held_out
);

   logic true_next;
   logic held_next;
   logic comp_next;

   // Only the phase change toward the rest level is let through, so no pulse is cut short
   always_comb begin
      true_next = true_out;
      if (tick_in && !(stop_in && (true_out == rest_in))) begin
         true_next = ~true_out;
      end
      held_next = stop_in && (true_next == rest_in);
      comp_next = (held_next && !rest_in) ? 1'b0 : ~true_next;
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         true_out <= 1'b0;
         comp_out <= 1'b0;
         held_out <= 1'b1;
      end else begin
         true_out <= true_next;
         comp_out <= comp_next;
         held_out <= held_next;
      end
   end

endmodule

// *** hw/ckg_output_ctrl.sv ***
`timescale 1ns/1ps
// Functional notes
// - Three-bit drive codes, 000 strongest, default 101
// - Wireless bit reloads all codes: 101 or 111
// - Five-bit programmed identification readable in low bits
// - Processor halt stops stoppable outputs after sampling
// - Stopped processor pair rests true high, comp low
// - Processor outputs resume glitch-free within two cycles
// - Peripheral halt drives stoppable single-ended outputs low
// - Free and serial clocks halt only if stoppable
// - Peripheral outputs resume within two peripheral periods
// - Shared pin is power good until sampled high
// - Power-down input synchronised before shutting down
// - Two low samples: outputs held low after falling
// - Clocks low first, then oscillator and VCO off
// - Stable clocks within 1.8 ms of wake
// - Three-stated differential outputs driven within 300 us
// - Outputs enabled a few cycles after PLL lock
module ckg_output_ctrl #(
   parameter int PU_LATENCY_CYCLES = ckg_pkg::PU_LATENCY_CYC,
   parameter int DIFF_DRIVE_CYCLES = ckg_pkg::DIFF_DRIVE_CYC,
   parameter logic [4:0] PROGRAMMED_ID = 5'h00 // Arbitrary value
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic arst_n_in,
   // Host pins
   input wire logic proc_clock_halt_n_in,
   input wire logic periph_clock_halt_n_in,
   input wire logic output_request_n_in,
   input wire logic power_good_pd_n_in,
   // Configuration levels
   input wire logic proc_stoppable_in,
   input wire logic free_periph_stoppable_in,
   input wire logic serial_ref_stoppable_in,
   input wire logic output_disable_in,
   input wire logic se_tristate_strap_in,
   input wire logic pll_lock_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_en_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_en_in,
   output logic [7:0] reg_rdata_out,
   // Differential clocks
   output ckg_pkg::ckg_diff_t proc_clock_out,
   output ckg_pkg::ckg_diff_t serial_reference_clock_out,
   output logic diff_oe_out,
   // Single-ended clocks
   output logic periph0_clock_out,
   output logic free_running_periph_clock_out,
   output logic usb_clock_out,
   output logic se_oe_out,
   output ckg_pkg::ckg_drive_t drive_code_out,
   // Analog enables
   output logic osc_enable_out,
   output logic vco_enable_out
);

   localparam int CNT_W = $clog2(PU_LATENCY_CYCLES + 1);
   localparam int NCLK = 5;

   ckg_pkg::ckg_state_t state_reg;
   ckg_pkg::ckg_state_t state_next;
   logic [7:0] drive_a_reg;
   logic [7:0] drive_b_reg;
   logic [1:0] sel_ext_reg;
   logic [2:0] wl_code;
   logic halt_s1_reg, halt_s2_reg, periph_s1_reg, req_s1_reg;
   logic pd_s1_reg, pd_s2_reg, pd_s3_reg;
   logic strap_reg;
   logic div_reg;
   logic [CNT_W-1:0] wake_cnt_reg;
   logic running, pd_low, proc_halt, periph_halt, src_quiet;
   logic [NCLK-1:0] g_tick, g_stop, g_rest, g_true, g_comp, g_held;

   // Register file
   assign wl_code = reg_wdata_in[ckg_pkg::WIRELESS_POS] ? ckg_pkg::CODE_WIRELESS : ckg_pkg::CODE_NORMAL;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         drive_a_reg <= ckg_pkg::DRIVE_A_RST;
         drive_b_reg <= ckg_pkg::DRIVE_B_RST;
         sel_ext_reg <= ckg_pkg::SEL_EXT_RST;
      end else if (reg_wr_en_in && reg_addr_in == ckg_pkg::REG_DRIVE_B &&
                   reg_wdata_in[ckg_pkg::WIRELESS_POS] != drive_b_reg[ckg_pkg::WIRELESS_POS]) begin
         // Mode change reloads every field; codes in the same write are overridden
         drive_a_reg <= {wl_code, wl_code, 1'b0, wl_code[1]};
         drive_b_reg <= {wl_code, 4'h0, reg_wdata_in[ckg_pkg::WIRELESS_POS]};
         sel_ext_reg <= {wl_code[2], wl_code[0]};
      end else if (reg_wr_en_in && reg_addr_in == ckg_pkg::REG_DRIVE_B) begin
         drive_b_reg <= reg_wdata_in & ckg_pkg::DRIVE_B_WMASK;
      end else if (reg_wr_en_in && reg_addr_in == ckg_pkg::REG_DRIVE_A) begin
         drive_a_reg <= reg_wdata_in & ckg_pkg::DRIVE_A_WMASK;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= ckg_pkg::UNMAPPED_READ;
      end else if (reg_rd_en_in) begin
         unique case (reg_addr_in)
            ckg_pkg::REG_DRIVE_A: reg_rdata_out <= drive_a_reg;
            ckg_pkg::REG_DRIVE_B: reg_rdata_out <= drive_b_reg;
            ckg_pkg::REG_IDENT: reg_rdata_out <= {ckg_pkg::IDENT_RSVD, PROGRAMMED_ID};
            default: reg_rdata_out <= ckg_pkg::UNMAPPED_READ;
         endcase
      end
   end

   assign drive_code_out.usb = drive_a_reg[ckg_pkg::USB_LSB +: 3];
   assign drive_code_out.periph0 = drive_a_reg[ckg_pkg::PERIPH0_LSB +: 3];
   assign drive_code_out.free_periph = drive_b_reg[ckg_pkg::FREE_LSB +: 3];
   assign drive_code_out.selectable = {sel_ext_reg[1], drive_a_reg[ckg_pkg::SEL_BIT1_POS], sel_ext_reg[0]};

   // Pin sampling
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         halt_s1_reg <= 1'b1;
         halt_s2_reg <= 1'b1;
         periph_s1_reg <= 1'b1;
         req_s1_reg <= 1'b1;
      end else begin
         halt_s1_reg <= proc_clock_halt_n_in;
         halt_s2_reg <= halt_s1_reg;
         periph_s1_reg <= periph_clock_halt_n_in;
         req_s1_reg <= output_request_n_in;
      end
   end

   // Third stage keeps the first synchroniser flop private
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pd_s1_reg <= 1'b0;
         pd_s2_reg <= 1'b0;
         pd_s3_reg <= 1'b0;
      end else begin
         pd_s1_reg <= power_good_pd_n_in;
         pd_s2_reg <= pd_s1_reg;
         pd_s3_reg <= pd_s2_reg;
      end
   end

   assign pd_low = !pd_s2_reg && !pd_s3_reg;
   assign proc_halt = !halt_s1_reg && !halt_s2_reg;
   assign periph_halt = !periph_s1_reg;
   assign src_quiet = !req_s1_reg || output_disable_in;
   assign running = (state_reg == ckg_pkg::ST_RUN);

   // Strap is caught while waiting for power good, never under reset
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_reg <= 1'b0;
      end else if (state_reg == ckg_pkg::ST_PWRGD) begin
         strap_reg <= se_tristate_strap_in;
      end
   end

   // Power sequencing
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ckg_pkg::ST_PWRGD: if (pd_s2_reg) state_next = ckg_pkg::ST_WAKE;
         ckg_pkg::ST_RUN: if (pd_low) state_next = ckg_pkg::ST_DRAIN;
         ckg_pkg::ST_DRAIN: if (&g_held) state_next = ckg_pkg::ST_OFF;
         ckg_pkg::ST_OFF: if (pd_s2_reg) state_next = ckg_pkg::ST_WAKE;
         ckg_pkg::ST_WAKE: begin
            if (pd_low) begin
               state_next = ckg_pkg::ST_DRAIN;
            end else if (pll_lock_in || wake_cnt_reg == CNT_W'(PU_LATENCY_CYCLES - 1)) begin
               state_next = ckg_pkg::ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= ckg_pkg::ST_PWRGD;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wake_cnt_reg <= '0;
      end else if (state_reg == ckg_pkg::ST_WAKE) begin
         wake_cnt_reg <= wake_cnt_reg + CNT_W'(1);
      end else begin
         wake_cnt_reg <= '0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_enable_out <= 1'b1;
         vco_enable_out <= 1'b1;
         diff_oe_out <= 1'b1;
         se_oe_out <= 1'b1;
      end else begin
         osc_enable_out <= (state_next != ckg_pkg::ST_OFF);
         vco_enable_out <= (state_next != ckg_pkg::ST_OFF);
         diff_oe_out <= !(state_next == ckg_pkg::ST_OFF && strap_reg);
         se_oe_out <= !(state_next == ckg_pkg::ST_OFF && strap_reg);
      end
   end

   // Peripheral clocks toggle every second cycle
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_reg <= 1'b0;
      end else begin
         div_reg <= ~div_reg;
      end
   end

   // Gate index: 0 proc, 1 serial ref, 2 periph0, 3 free periph, 4 usb
   always_comb begin
      g_tick = {div_reg, div_reg, div_reg, 1'b1, 1'b1};
      g_stop[0] = !running || (proc_stoppable_in && proc_halt);
      g_rest[0] = running;
      g_stop[1] = !running || (serial_ref_stoppable_in && (periph_halt || src_quiet));
      g_rest[1] = running && !src_quiet;
      g_stop[2] = !running || periph_halt || output_disable_in;
      g_rest[2] = 1'b0;
      g_stop[3] = !running || (free_periph_stoppable_in && (periph_halt || output_disable_in));
      g_rest[3] = 1'b0;
      g_stop[4] = !running || output_disable_in;
      g_rest[4] = 1'b0;
   end

   for (genvar gi = 0; gi < NCLK; gi++) begin : g_gate
      ckg_clk_gate u_gate (
         .ref_clk_in(ref_clk_in),
         .arst_n_in(arst_n_in),
         .tick_in(g_tick[gi]),
         .stop_in(g_stop[gi]),
         .rest_in(g_rest[gi]),
         .true_out(g_true[gi]),
         .comp_out(g_comp[gi]),
         .held_out(g_held[gi])
      );
   end

   assign proc_clock_out = '{true_ph: g_true[0], comp_ph: g_comp[0]};
   assign serial_reference_clock_out = '{true_ph: g_true[1], comp_ph: g_comp[1]};
   assign periph0_clock_out = g_true[2];
   assign free_running_periph_clock_out = g_true[3];
   assign usb_clock_out = g_true[4];

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   logic all_low;
   assign all_low = !(|g_true) && !g_comp[0] && !g_comp[1];

   a_proc_stop_rest: assert property (
      (running && proc_stoppable_in && !proc_clock_halt_n_in)[*8]
      |-> proc_clock_out.true_ph && !proc_clock_out.comp_ph)
      else $error("Processor pair not stopped in time");

   a_proc_held_high: assert property (
      // First run cycle still shows the low rest level of wake
      (g_held[0] && running && $past(running)) |-> proc_clock_out.true_ph && !proc_clock_out.comp_ph)
      else $error("Stopped processor pair not at rest level");

   a_proc_resume_fast: assert property (
      (running && proc_clock_halt_n_in)[*5] |-> $changed(proc_clock_out.true_ph))
      else $error("Processor clock did not resume");

   a_periph_held_low: assert property (
      (running && !periph_clock_halt_n_in)[*6] |-> !periph0_clock_out)
      else $error("Peripheral clock not driven low");

   a_free_runs_on: assert property (
      (running && !free_periph_stoppable_in && !output_disable_in)[*6]
      |-> ##[0:1] $changed(free_running_periph_clock_out))
      else $error("Non-stoppable free clock halted");

   a_periph_resume_fast: assert property (
      (running && periph_clock_halt_n_in && !output_disable_in)[*7]
      |-> ##[0:1] $changed(periph0_clock_out))
      else $error("Peripheral clock did not resume");

   a_pwrgd_wait_high: assert property (
      (state_reg == ckg_pkg::ST_PWRGD && !power_good_pd_n_in)[*3] |=> state_reg == ckg_pkg::ST_PWRGD)
      else $error("Left power-good wait without high sample");

   a_pd_outputs_low: assert property (
      state_reg == ckg_pkg::ST_OFF |-> all_low)
      else $error("Clock running during power-down");

   a_osc_after_low: assert property (
      $fell(osc_enable_out) |-> all_low && $past(all_low))
      else $error("Oscillator stopped before clocks were low");

   a_wake_bounded: assert property (
      state_reg == ckg_pkg::ST_WAKE |-> wake_cnt_reg < CNT_W'(PU_LATENCY_CYCLES))
      else $error("Power-up latency exceeded");

   a_wake_diff_drive: assert property (
      (state_reg == ckg_pkg::ST_WAKE && wake_cnt_reg < CNT_W'(DIFF_DRIVE_CYCLES)) |-> diff_oe_out)
      else $error("Differential outputs not driven after wake");

   a_wireless_codes: assert property (
      (reg_wr_en_in && reg_addr_in == ckg_pkg::REG_DRIVE_B && reg_wdata_in[0] && !drive_b_reg[0])
      |=> drive_code_out == {4{ckg_pkg::CODE_WIRELESS}})
      else $error("Wireless mode did not load weakest codes");

   a_ident_read: assert property (
      (reg_rd_en_in && reg_addr_in == ckg_pkg::REG_IDENT) |=> reg_rdata_out[4:0] == PROGRAMMED_ID)
      else $error("Identification field read wrong");

   c_proc_stop: cover property (running ##1 g_held[0] && proc_clock_out.true_ph);
   c_periph_stop: cover property (running ##1 g_held[2] ##[1:8] !g_held[2]);
   c_pd_cycle: cover property (state_reg == ckg_pkg::ST_OFF ##[1:100] running);
   c_wireless: cover property (drive_code_out.usb == ckg_pkg::CODE_WIRELESS);

endmodule

// *** verification/ckg_host_model.sv ***
`timescale 1ns/1ps
module ckg_host_model (
   // Clock
   input wire logic ref_clk_in,
   // Host pins
   output logic proc_halt_n_out,
   output logic periph_halt_n_out,
   output logic request_n_out,
   output logic pd_n_out
);
   // Power good starts low, as at supply ramp
   initial begin
      proc_halt_n_out = 1'b1;
      periph_halt_n_out = 1'b1;
      request_n_out = 1'b1;
      pd_n_out = 1'b0;
   end
   // Pins move on the falling edge, clear of the sampling edge
   task automatic set_pins(input logic [3:0] v);
      @(negedge ref_clk_in);
      {proc_halt_n_out, periph_halt_n_out, request_n_out, pd_n_out} = v;
   endtask
   // Power good, then power-down well inside the allowed window
   task automatic good_then_down();
      set_pins(4'hf);
      repeat (20) @(negedge ref_clk_in);
      pd_n_out = 1'b0;
   endtask
endmodule

// *** verification/clock_output_stop_powerdown_control_tb.sv ***
`timescale 1ns/1ps
module clock_output_stop_powerdown_control_tb;
   localparam int PU = 50;
   // Identification value is arbitrary
   localparam logic [4:0] ID = 5'h0b;
   logic ref_clk_in = 1'b0;
   logic arst_n_in;
   logic proc_en, free_en, ser_en, out_dis, strap, lock;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr_en;
   logic rd_en;
   logic [7:0] rdata;
   logic ph_n, pp_n, rq_n, pd_n, diff_oe, p0_clk, free_clk, usb_clk, se_oe, osc_en, vco_en;
   logic osc_last = 1'b1;
   ckg_pkg::ckg_diff_t proc_clk, ser_clk;
   ckg_pkg::ckg_drive_t codes;
   int err_total = 0;
   int samples_checked = 0;
   always #12.5 ref_clk_in = ~ref_clk_in;
   ckg_host_model host (.ref_clk_in(ref_clk_in), .proc_halt_n_out(ph_n), .periph_halt_n_out(pp_n),
      .request_n_out(rq_n), .pd_n_out(pd_n));
   ckg_output_ctrl #(.PU_LATENCY_CYCLES(PU), .DIFF_DRIVE_CYCLES(20), .PROGRAMMED_ID(ID)) dut (
      .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .proc_clock_halt_n_in(ph_n),
      .periph_clock_halt_n_in(pp_n), .output_request_n_in(rq_n), .power_good_pd_n_in(pd_n),
      .proc_stoppable_in(proc_en), .free_periph_stoppable_in(free_en), .serial_ref_stoppable_in(ser_en),
      .output_disable_in(out_dis), .se_tristate_strap_in(strap), .pll_lock_in(lock),
      .reg_addr_in(addr), .reg_wr_en_in(wr_en), .reg_wdata_in(wdata), .reg_rd_en_in(rd_en),
      .reg_rdata_out(rdata), .proc_clock_out(proc_clk), .serial_reference_clock_out(ser_clk),
      .diff_oe_out(diff_oe), .periph0_clock_out(p0_clk), .free_running_periph_clock_out(free_clk),
      .usb_clock_out(usb_clk), .se_oe_out(se_oe), .drive_code_out(codes),
      .osc_enable_out(osc_en), .vco_enable_out(vco_en));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge ref_clk_in);
      wr_en = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk_in);
      addr = a;
      rd_en = 1'b1;
      @(negedge ref_clk_in);
      rd_en = 1'b0;
      check(rdata, exp);
   endtask
   function automatic logic pick(input int i);
      case (i)
         0: pick = proc_clk.true_ph;
         1: pick = ser_clk.true_ph;
         2: pick = p0_clk;
         3: pick = free_clk;
         default: pick = usb_clk;
      endcase
   endfunction
   // Running means more than one edge seen in the window
   task automatic runs(input int i, input int n, input logic exp);
      int t = 0;
      logic last;
      last = pick(i);
      repeat (n) begin
         @(negedge ref_clk_in);
         if (pick(i) !== last) t++;
         last = pick(i);
      end
      check(t > 1, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   // Oscillator may only stop once every clock is parked low
   always @(negedge ref_clk_in) begin
      if (arst_n_in && osc_last === 1'b1 && osc_en === 1'b0)
         check({proc_clk, ser_clk, p0_clk, free_clk, usb_clk}, 16'h0000);
      osc_last <= osc_en;
   end
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      err_total++;
      $display("[ERR] %0t: run did not finish", $time);
      end_of_test();
   end
   initial begin
      arst_n_in = 1'b0;
      // Processor, free and serial clocks stoppable; no disable, strap or lock
      {proc_en, free_en, ser_en, out_dis, strap, lock} = 6'h38;
      addr = 8'h00;
      wdata = 8'h00;
      {wr_en, rd_en} = 2'h0;
      idle(3);
      arst_n_in = 1'b1;
      check(codes, {4{ckg_pkg::CODE_NORMAL}});
      rd_chk(ckg_pkg::REG_DRIVE_A, ckg_pkg::DRIVE_A_RST);
      rd_chk(ckg_pkg::REG_DRIVE_B, ckg_pkg::DRIVE_B_RST);
      rd_chk(ckg_pkg::REG_IDENT, {ckg_pkg::IDENT_RSVD, ID});
      rd_chk(8'h0f, 8'h00);
      reg_wr(8'h0c, 8'h00);
      check(codes, 12'h02d);
      reg_wr(8'h0c, 8'hff);
      check(codes, 12'hfef);
      rd_chk(8'h0c, 8'hfd);
      reg_wr(8'h0d, 8'h01);
      check(codes, 12'hfff);
      rd_chk(8'h0d, 8'he1);
      reg_wr(8'h0d, 8'h00);
      reg_wr(8'h0f, 8'hff);
      check(codes, 12'hb6d);
      rd_chk(8'h0c, 8'hb4);
      $display("Register test done");
      runs(0, 16, 1'b0);
      host.set_pins(4'hf);
      idle(PU + 10);
      runs(0, 32, 1'b1);
      check({diff_oe, osc_en, vco_en}, 3'h7);
      $display("Power-up test done");
      for (int s = 1; s >= 0; s--) begin
         proc_en = s[0];
         host.set_pins(4'h7);
         idle(8);
         if (s == 1) check(proc_clk, 2'b10);
         runs(0, 32, !s[0]);
         host.set_pins(4'hf);
         runs(0, 32, 1'b1);
      end
      $display("Processor halt test done");
      for (int s = 1; s >= 0; s--) begin
         free_en = s[0];
         ser_en = s[0];
         host.set_pins(4'hb);
         idle(8);
         check(p0_clk, 1'b0);
         if (s == 1) check(ser_clk, 2'b10);
         runs(2, 32, 1'b0);
         runs(4, 32, 1'b1);
         runs(3, 32, !s[0]);
         runs(1, 32, !s[0]);
         host.set_pins(4'hf);
         runs(2, 32, 1'b1);
         runs(3, 32, 1'b1);
      end
      $display("Peripheral halt test done");
      // Request reaches only the stoppable serial clock; disable also stops periph0 and usb, which have no stoppable setting
      free_en = 1'b1;
      ser_en = 1'b1;
      host.set_pins(4'hd);
      idle(8);
      check(ser_clk, 2'b00);
      runs(2, 32, 1'b1);
      host.set_pins(4'hf);
      out_dis = 1'b1;
      idle(8);
      check({ser_clk, free_clk, usb_clk}, 4'h0);
      out_dis = 1'b0;
      $display("Request and disable test done");
      lock = 1'b1;
      host.set_pins(4'he);
      idle(1);
      check(osc_en, 1'b1);
      idle(20);
      check({proc_clk, ser_clk, p0_clk, free_clk, usb_clk}, 7'h00);
      check({osc_en, vco_en, se_oe}, 3'h1);
      host.set_pins(4'hf);
      idle(20);
      check({diff_oe, osc_en}, 2'h3);
      runs(0, 32, 1'b1);
      $display("Power-down test done");
      arst_n_in = 1'b0;
      strap = 1'b1;
      host.set_pins(4'he);
      idle(3);
      arst_n_in = 1'b1;
      host.good_then_down();
      idle(30);
      check({se_oe, osc_en, p0_clk}, 3'h0);
      $display("Initial power-down test done");
      end_of_test();
   end
endmodule
